//--- core/smk_device.sv
/*
 * Gauge device end: key sequence checker, mode register, status flags and the
 * user parameter store with mode-dependent access.
 * Assumes the host writes control words as one-cycle strobes on clk.
 */
// How it works
// - Each unlocking mode move needs its own key pair
// - Second key must directly follow the first
// - Host keys never equal a subcommand code
// - Sealed flag set when sealed, cleared on unseal
// - Full-access flag cleared on full-access key pair
// - Two-byte keys kept in parameter store
// - Keys rewritable only in full-access mode
// - Supplied key words are byte swapped
// - Store holds three 32-byte blocks, default zero
// - Sealed: block A read-only, blocks B and C writable, private hidden
`timescale 1ns/1ps
`default_nettype none

module smk_device
  import smk_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  smk_if.dev        link,
  output logic      mode_sealed,
  output logic      mode_full
);

  // ****************************************************************
  // Parameter store
  // ****************************************************************
  logic [BYTE_W-1:0] nv_q [NV_BYTES];
  logic              wr_hit;
  smk_idx_t          acc_idx;
  logic              is_mi;
  logic              is_key;
  logic              rd_ok;
  logic              wr_ok;

  smk_mode_e         mode_q;
  smk_mode_e         mode_d;
  logic              half_q;
  logic              half_d;
  smk_idx_t          key_base;
  logic [CMD_W-1:0]  exp_first;
  logic [CMD_W-1:0]  exp_second;

  // ****************************************************************
  // Access decode
  // ****************************************************************
  // subclass 58 decode
  always_comb begin
    is_mi   = (link.par_subclass == MI_SUBCLASS) && (link.par_offset < MI_BYTES);
    is_key  = (link.par_subclass == KEY_SUBCLASS) && (link.par_offset < KEY_BYTES);
    acc_idx = is_mi ? link.par_offset : smk_idx_t'(MI_BYTES + link.par_offset);
  end

  always_comb begin
    rd_ok = is_mi || (is_key && (mode_q != SMK_SEALED));
    wr_ok = (is_mi && ((mode_q != SMK_SEALED) || (link.par_offset >= MI_BLK_BYTES)))
            || (is_key && (mode_q == SMK_FULL));
    wr_hit = link.par_req && link.par_we && wr_ok;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NV_BYTES; gi++) begin : g_nv
      // Clamped so the info bytes never form a negative key select
      localparam int                KEY_POS = (gi >= int'(MI_BYTES)) ? (gi - int'(MI_BYTES)) : 0;
      localparam logic [BYTE_W-1:0] RST_VAL =
        (gi >= int'(MI_BYTES)) ? KEY_DEFAULT[BYTE_W*KEY_POS +: BYTE_W] : MI_DEFAULT;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          nv_q[gi] <= RST_VAL;
        end else if (wr_hit && (acc_idx == smk_idx_t'(gi))) begin
          nv_q[gi] <= link.par_wdata;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Parameter access answer
  // ****************************************************************
  // Answer strobe one cycle after each request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.par_ack <= 1'b0;
    end else begin
      link.par_ack <= link.par_req;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.par_err <= 1'b0;
    end else begin
      link.par_err <= link.par_req && (link.par_we ? !wr_ok : !rd_ok);
    end
  end

  // Read byte, zero on writes and refused reads so nothing private leaks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.par_rdata <= 8'h00;
    end else if (link.par_req && !link.par_we && rd_ok) begin
      link.par_rdata <= nv_q[acc_idx];
    end else if (link.par_req) begin
      link.par_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // Key sequence checker
  // ****************************************************************
  // swapped key compare
  always_comb begin
    key_base   = (mode_q == SMK_SEALED) ? UNSEAL_BASE : FULL_BASE;
    exp_first  = {nv_q[key_base], nv_q[smk_idx_t'(key_base + 7'h01)]};
    exp_second = {nv_q[smk_idx_t'(key_base + 7'h02)], nv_q[smk_idx_t'(key_base + 7'h03)]};
  end

  always_comb begin
    mode_d = mode_q;
    half_d = half_q;
    if (link.cmd_wr) begin
      if (half_q && (mode_q != SMK_FULL) && (link.cmd_word == exp_second)) begin
        mode_d = (mode_q == SMK_SEALED) ? SMK_UNSEALED : SMK_FULL;
        half_d = 1'b0;
      end else if ((link.cmd_word == SEAL_SUBCMD) && (mode_q != SMK_SEALED)) begin
        mode_d = SMK_SEALED;
        half_d = 1'b0;
      end else begin
        half_d = !half_q && (mode_q != SMK_FULL) && (link.cmd_word == exp_first);
      end
    end
  end

  // ****************************************************************
  // Mode register
  // ****************************************************************
  // Current security mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= SMK_SEALED;
    end else begin
      mode_q <= mode_d;
    end
  end

  // First key of a pair seen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      half_q <= 1'b0;
    end else begin
      half_q <= half_d;
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Flags follow mode_d so they move on the same edge as the mode
  // sealed flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.sealed_flag <= 1'b1;
    end else begin
      link.sealed_flag <= (mode_d == SMK_SEALED);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.full_access_state_flag <= 1'b1;
    end else begin
      link.full_access_state_flag <= (mode_d != SMK_FULL);
    end
  end

  // Sealed mode level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_sealed <= 1'b1;
    end else begin
      mode_sealed <= (mode_d == SMK_SEALED);
    end
  end

  // Full access mode level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_full <= 1'b0;
    end else begin
      mode_full <= (mode_d == SMK_FULL);
    end
  end

endmodule : smk_device

`default_nettype wire

//--- core/smk_pkg.sv
/*
 * Shared constants for the security mode key unlock block: modes, subcommand
 * code, parameter store layout and key defaults.
 * Assumes both link ends and the interface import this package.
 */
`default_nettype none

package smk_pkg;

  // ****************************************************************
  // Security modes
  // ****************************************************************
  typedef enum logic [1:0] {
    SMK_SEALED,
    SMK_UNSEALED,
    SMK_FULL
  } smk_mode_e;

  localparam int unsigned CMD_W  = 16;
  localparam int unsigned SC_W   = 8;
  localparam int unsigned OFS_W  = 7;
  localparam int unsigned BYTE_W = 8;

  // Subcommand that returns the device to sealed mode
  localparam logic [CMD_W-1:0] SEAL_SUBCMD = 16'h0020;

  // ****************************************************************
  // Parameter store layout
  // ****************************************************************
  localparam logic [SC_W-1:0]  MI_SUBCLASS  = 8'h3a;      // 58
  localparam logic [OFS_W-1:0] MI_BLK_BYTES = 7'h20;      // 32 per block
  localparam logic [OFS_W-1:0] MI_BYTES     = 7'h60;      // blocks A, B, C
  localparam logic [BYTE_W-1:0] MI_DEFAULT  = 8'h00;
  localparam logic [SC_W-1:0]  KEY_SUBCLASS = 8'h70;
  localparam logic [OFS_W-1:0] KEY_BYTES    = 7'h08;
  localparam int unsigned      NV_BYTES     = 104;        // MI_BYTES + KEY_BYTES
  localparam logic [OFS_W-1:0] UNSEAL_BASE  = 7'h60;
  localparam logic [OFS_W-1:0] FULL_BASE    = 7'h64;

  // Default keys in read-back byte order: unseal at bytes 0..3, full at 4..7
  localparam logic [63:0] KEY_DEFAULT = 64'hffff_ffff_7856_3412;

  typedef logic [OFS_W-1:0] smk_idx_t;

endpackage : smk_pkg

`default_nettype wire

//--- core/smk_if.sv
/*
 * Link between the host controller end and the gauge device end.
 * Assumes one clock shared by both ends; no clocking block.
 */
`timescale 1ns/1ps
`default_nettype none

interface smk_if;
  import smk_pkg::*;

  logic                 cmd_wr;
  logic [CMD_W-1:0]     cmd_word;
  logic                 par_req;
  logic                 par_we;
  logic [SC_W-1:0]      par_subclass;
  logic [OFS_W-1:0]     par_offset;
  logic [BYTE_W-1:0]    par_wdata;
  logic                 par_ack;
  logic                 par_err;
  logic [BYTE_W-1:0]    par_rdata;
  logic                 sealed_flag;
  logic                 full_access_state_flag;

  modport dev (
    input  cmd_wr, cmd_word, par_req, par_we, par_subclass, par_offset, par_wdata,
    output par_ack, par_err, par_rdata, sealed_flag, full_access_state_flag
  );

  modport hst (
    output cmd_wr, cmd_word, par_req, par_we, par_subclass, par_offset, par_wdata,
    input  par_ack, par_err, par_rdata, sealed_flag, full_access_state_flag
  );

endinterface : smk_if

`default_nettype wire

//--- core/smk_host.sv
/*
 * Host controller end: sends key pairs back to back in swapped byte order,
 * sends the seal subcommand, and forwards parameter store accesses.
 * Assumes the user side holds request fields while valid and ready meet.
 */
`timescale 1ns/1ps
`default_nettype none

module smk_host
  import smk_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  smk_if.hst                     link,
  input  wire logic              key_valid,
  output logic                   key_ready,
  input  wire logic              key_seal,
  input  wire logic [CMD_W-1:0]  key_first,
  input  wire logic [CMD_W-1:0]  key_second,
  input  wire logic              pr_valid,
  output logic                   pr_ready,
  input  wire logic              pr_we,
  input  wire logic [SC_W-1:0]   pr_subclass,
  input  wire logic [OFS_W-1:0]  pr_offset,
  input  wire logic [BYTE_W-1:0] pr_wdata,
  output logic                   pr_done,
  output logic                   pr_err,
  output logic [BYTE_W-1:0]      pr_rdata,
  output logic                   st_sealed,
  output logic                   st_full_access_state_flag
);

  logic             second_q;
  logic [CMD_W-1:0] hold_q;
  logic             busy_q;

  assign key_ready = !second_q;
  assign pr_ready  = !busy_q;

  // ****************************************************************
  // Key sender
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.cmd_wr   <= 1'b0;
      link.cmd_word <= 16'h0000;
      second_q      <= 1'b0;
      hold_q        <= 16'h0000;
    end else if (second_q) begin
      link.cmd_wr   <= 1'b1;
      link.cmd_word <= hold_q;
      second_q      <= 1'b0;
    end else if (key_valid) begin
      link.cmd_wr   <= 1'b1;
      link.cmd_word <= key_seal ? SEAL_SUBCMD : {key_first[7:0], key_first[15:8]};
      hold_q        <= {key_second[7:0], key_second[15:8]};
      second_q      <= !key_seal;
    end else begin
      link.cmd_wr   <= 1'b0;
    end
  end

  // ****************************************************************
  // Parameter access forwarding
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.par_req      <= 1'b0;
      link.par_we       <= 1'b0;
      link.par_subclass <= 8'h00;
      link.par_offset   <= 7'h00;
      link.par_wdata    <= 8'h00;
      busy_q            <= 1'b0;
      pr_done           <= 1'b0;
      pr_err            <= 1'b0;
      pr_rdata          <= 8'h00;
    end else begin
      link.par_req <= pr_valid && !busy_q;
      pr_done      <= busy_q && link.par_ack;
      if (pr_valid && !busy_q) begin
        link.par_we       <= pr_we;
        link.par_subclass <= pr_subclass;
        link.par_offset   <= pr_offset;
        link.par_wdata    <= pr_wdata;
        busy_q            <= 1'b1;
      end else if (busy_q && link.par_ack) begin
        busy_q   <= 1'b0;
        pr_err   <= link.par_err;
        pr_rdata <= link.par_rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_sealed                 <= 1'b1;
      st_full_access_state_flag <= 1'b1;
    end else begin
      st_sealed                 <= link.sealed_flag;
      st_full_access_state_flag <= link.full_access_state_flag;
    end
  end

endmodule : smk_host

`default_nettype wire

//--- tb/smk_checker.sv
/*
 * Checker on the link between host and device ends: mode flags and parameter answers.
 * Assumes one clock, an active-low reset, and unseal keys left at their defaults.
 */
`timescale 1ns/1ps
`default_nettype none

module smk_checker
  import smk_pkg::*;
(
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             cmd_wr,
  input wire logic [CMD_W-1:0] cmd_word,
  input wire logic             par_req,
  input wire logic             par_we,
  input wire logic [SC_W-1:0]  par_subclass,
  input wire logic [OFS_W-1:0] par_offset,
  input wire logic             par_ack,
  input wire logic             par_err,
  input wire logic             sealed_flag,
  input wire logic             full_access_state_flag
);
  localparam logic [CMD_W-1:0] K0 = {KEY_DEFAULT[7:0], KEY_DEFAULT[15:8]};
  localparam logic [CMD_W-1:0] K1 = {KEY_DEFAULT[23:16], KEY_DEFAULT[31:24]};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // Key sequences
  // ****************************************************************
  sequence s_first;
    sealed_flag && cmd_wr && cmd_word == K0;
  endsequence
  sequence s_pair;
    s_first ##1 (cmd_wr && cmd_word == K1);
  endsequence
  sequence s_broken;
    s_first ##1 (cmd_wr && cmd_word != K1);
  endsequence

  AST_UNSEAL: assert property (s_pair |=> !sealed_flag && full_access_state_flag)
    else $error("unseal pair did not clear sealed flag");
  AST_BROKEN: assert property (s_broken |=> sealed_flag)
    else $error("broken pair changed mode");
  AST_SS_CAUSE: assert property ($changed(sealed_flag) |-> $past(cmd_wr))
    else $error("sealed flag moved without a control word");
  AST_FAS_CAUSE: assert property ($fell(full_access_state_flag) |-> $past(cmd_wr) && !$past(sealed_flag))
    else $error("full access entered from wrong mode");
  AST_SEAL: assert property (cmd_wr && cmd_word == SEAL_SUBCMD |=> sealed_flag && full_access_state_flag)
    else $error("seal word did not seal");
  AST_ACK: assert property (par_req |=> par_ack ##1 !par_ack)
    else $error("parameter answer not one cycle after request");
  AST_KEY_WR: assert property (par_req && par_we && par_subclass == KEY_SUBCLASS && full_access_state_flag
    |=> par_err)
    else $error("key write taken outside full access");
  AST_BLK_A: assert property (par_req && par_we && sealed_flag && par_subclass == MI_SUBCLASS
    && par_offset < MI_BLK_BYTES |=> par_err)
    else $error("block A written while sealed");
endmodule : smk_checker

`default_nettype wire

//--- tb/testbench.sv
/*
 * Bench joining host and device ends; runs key and parameter store scenarios.
 * Assumes the core package, interface and both ends are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", n, e, a); end end

module testbench
  import smk_pkg::*;
;
  logic              clk = 1'b0, rstn = 1'b0, key_valid = 1'b0, key_seal = 1'b0, pr_valid = 1'b0, pr_we = 1'b0;
  logic [CMD_W-1:0]  key_first = '0, key_second = '0;
  logic [SC_W-1:0]   pr_subclass = '0;
  logic [OFS_W-1:0]  pr_offset = '0;
  logic [BYTE_W-1:0] pr_wdata = '0, pr_rdata;
  logic              key_ready, pr_ready, pr_done, pr_err, st_sealed, st_full_access_state_flag, mode_sealed, mode_full;
  int                failures = 0, samples_checked = 0, cyc = 0;
  smk_if             lk ();

  smk_device i_smk_device (.clk, .rstn, .link(lk.dev), .mode_sealed, .mode_full);
  smk_host i_smk_host (.clk, .rstn, .link(lk.hst), .key_valid, .key_ready, .key_seal, .key_first, .key_second,
    .pr_valid, .pr_ready, .pr_we, .pr_subclass, .pr_offset, .pr_wdata, .pr_done, .pr_err, .pr_rdata,
    .st_sealed, .st_full_access_state_flag);
  smk_checker i_smk_checker (.clk, .rstn, .cmd_wr(lk.cmd_wr), .cmd_word(lk.cmd_word), .par_req(lk.par_req),
    .par_we(lk.par_we), .par_subclass(lk.par_subclass), .par_offset(lk.par_offset), .par_ack(lk.par_ack),
    .par_err(lk.par_err), .sealed_flag(lk.sealed_flag), .full_access_state_flag(lk.full_access_state_flag));

  // ****************************************************************
  // Drivers and checks
  // ****************************************************************
  task automatic keys(input logic [15:0] a, input logic [15:0] b, input logic s);
    @(negedge clk);
    while (!key_ready) @(negedge clk);
    {key_valid, key_seal, key_first, key_second} = {1'b1, s, a, b};
    @(negedge clk);
    key_valid = 1'b0;
    `CHK("cmd_wr", 1'b1, lk.cmd_wr)
    `CHK("cmd_word", s ? SEAL_SUBCMD : {a[7:0], a[15:8]}, lk.cmd_word)
    `CHK("key_ready", s, key_ready)
    repeat (4) @(negedge clk);
  endtask : keys

  task automatic mode_is(input logic s, input logic f);
    `CHK("sealed_flag", s, lk.sealed_flag)
    `CHK("full_access_state_flag", ~f, lk.full_access_state_flag)
    `CHK("mode_sealed", s, mode_sealed)
    `CHK("mode_full", f, mode_full)
    `CHK("st_sealed", s, st_sealed)
    `CHK("st_full_access_state_flag", ~f, st_full_access_state_flag)
  endtask : mode_is

  task automatic acc(input logic w, input logic [7:0] sc, input logic [6:0] o, input logic [7:0] d,
                     input logic e_err, input logic [7:0] e_rd);
    int i;
    @(negedge clk);
    while (!pr_ready) @(negedge clk);
    {pr_valid, pr_we, pr_subclass, pr_offset, pr_wdata} = {1'b1, w, sc, o, d};
    @(negedge clk);
    pr_valid = 1'b0;
    `CHK("pr_ready", 1'b0, pr_ready)
    for (i = 0; i < 8 && pr_done !== 1'b1; i++) @(negedge clk);
    `CHK("pr_done", 1'b1, pr_done)
    `CHK("pr_err", e_err, pr_err)
    if (!w) `CHK("pr_rdata", e_rd, pr_rdata)
  endtask : acc

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_sealed();
    int i;
    mode_is(1'b1, 1'b0);
    for (i = 0; i < 96; i += 19) acc(1'b0, MI_SUBCLASS, i[6:0], 8'h00, 1'b0, MI_DEFAULT);
    acc(1'b1, MI_SUBCLASS, 7'h1f, 8'h5a, 1'b1, 8'h00);
    acc(1'b0, MI_SUBCLASS, 7'h1f, 8'h00, 1'b0, MI_DEFAULT);
    acc(1'b1, MI_SUBCLASS, 7'h40, 8'h5a, 1'b0, 8'h00);
    acc(1'b0, MI_SUBCLASS, 7'h40, 8'h00, 1'b0, 8'h5a);
    acc(1'b0, MI_SUBCLASS, 7'h60, 8'h00, 1'b1, 8'h00);
    acc(1'b0, KEY_SUBCLASS, 7'h00, 8'h00, 1'b1, 8'h00);
  endtask : t_sealed

  task automatic t_bad();
    keys(16'h3412, 16'h0000, 1'b0);
    mode_is(1'b1, 1'b0);
    keys(16'h1234, 16'h5678, 1'b0);
    mode_is(1'b1, 1'b0);
    keys(16'hffff, 16'hffff, 1'b0);
    mode_is(1'b1, 1'b0);
  endtask : t_bad

  task automatic t_unseal();
    int i;
    keys(16'h3412, 16'h7856, 1'b0);
    mode_is(1'b0, 1'b0);
    for (i = 0; i < 4; i++) acc(1'b0, KEY_SUBCLASS, i[6:0], 8'h00, 1'b0, KEY_DEFAULT[8*i+:8]);
    acc(1'b1, KEY_SUBCLASS, 7'h04, 8'ha5, 1'b1, 8'h00);
    acc(1'b1, MI_SUBCLASS, 7'h00, 8'h3c, 1'b0, 8'h00);
  endtask : t_unseal

  task automatic t_full();
    keys(16'hffff, 16'hffff, 1'b0);
    mode_is(1'b0, 1'b1);
    acc(1'b1, KEY_SUBCLASS, 7'h04, 8'ha5, 1'b0, 8'h00);
    acc(1'b0, KEY_SUBCLASS, 7'h04, 8'h00, 1'b0, 8'ha5);
    keys(16'h0000, 16'h0000, 1'b1);
    mode_is(1'b1, 1'b0);
    keys(16'h3412, 16'h7856, 1'b0);
    keys(16'hffff, 16'hffff, 1'b0);
    mode_is(1'b0, 1'b0);
    keys(16'hffa5, 16'hffff, 1'b0);
    mode_is(1'b0, 1'b1);
  endtask : t_full

  task automatic results();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end

  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_sealed();
    t_bad();
    t_unseal();
    t_full();
    results();
  end
endmodule : testbench

`default_nettype wire
